// ==== core/isr_pkg.sv ====
package isr_pkg;

  // ****************************************
  // addressing
  // ****************************************
  localparam logic [4:0] ADDR_HI         = 5'h13;
  localparam logic [7:0] FIXED_ADDR_BYTE = 8'h98;
  // strap class {pin with scl high/sda low, pin with scl low/sda high}:
  // 0 ground, 1 sda, 2 scl, 3 supply; two low address bits per class
  localparam logic [7:0] STRAP_MAP_DEF   = 8'h78;

  // ****************************************
  // framing
  // ****************************************
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_BIT   = 4'h8;

  // ****************************************
  // timing
  // ****************************************
  localparam longint LINK_PERIOD_PS = 64'd15000;
  localparam longint TIMEOUT_MS     = 64'd31;
  localparam longint PS_PER_MS      = 64'd1000000000;
  localparam longint TIMEOUT_CYC    = (TIMEOUT_MS * PS_PER_MS) / LINK_PERIOD_PS;
  localparam int     TMO_W          = 22;
  localparam longint CLK_HZ         = 64'd100000000;
  localparam longint SCL_HZ         = 64'd400000;
  localparam longint QTR_CYC        = CLK_HZ / (SCL_HZ * 64'd4);
  localparam int     QTR_W          = 8;

  // ****************************************
  // state machines
  // ****************************************
  typedef enum logic [2:0] {
    SL_IDLE = 3'h0,
    SL_ADDR = 3'h1,
    SL_RECV = 3'h2,
    SL_ACK  = 3'h3,
    SL_SEND = 3'h4,
    SL_MACK = 3'h5
  } isr_sl_state_t;

  typedef enum logic [2:0] {
    MS_IDLE  = 3'h0,
    MS_START = 3'h1,
    MS_BIT   = 3'h2,
    MS_STOP  = 3'h3,
    MS_DONE  = 3'h4
  } isr_ms_state_t;

endpackage

// ==== core/isr_bus_if.sv ====
`timescale 1ns/1ns
interface isr_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired-and with pull-ups
  assign scl = ~(m_scl_oe & ~m_scl_o);
  assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));

  modport master (
    output m_scl_o,
    output m_scl_oe,
    output m_sda_o,
    output m_sda_oe,
    input  scl,
    input  sda
  );

  modport slave (
    output s_sda_o,
    output s_sda_oe,
    input  scl,
    input  sda
  );
endinterface

// ==== core/isr_slave.sv ====
`timescale 1ns/1ns
module isr_slave #(
  parameter bit          FIXED_VARIANT  = 1'b0,
  parameter logic [7:0]  STRAP_MAP      = isr_pkg::STRAP_MAP_DEF,
  parameter int unsigned TIMEOUT_CYCLES = int'(isr_pkg::TIMEOUT_CYC)
) (
  input  wire logic       link_clk,
  input  wire logic       rst_n,
  isr_bus_if.slave        bus,
  input  wire logic       address_select_pin,
  input  wire logic       timeout_disable,
  output logic [7:0]      ptr,
  input  wire logic [7:0] ptr_next,
  output logic [7:0]      wr_addr,
  output logic [7:0]      wr_data,
  output logic            wr_en,
  input  wire logic [7:0] rd_data,
  output logic            rd_en
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                  scl_s1;
    logic                  scl_s2;
    logic                  scl_p;
    logic                  sda_s1;
    logic                  sda_s2;
    logic                  sda_p;
    logic                  pin_s1;
    logic                  pin_s2;
    logic                  p10;
    logic                  p01;
    logic                  p01_seen;
    isr_pkg::isr_sl_state_t st;
    logic [3:0]            bitc;
    logic [7:0]            sh;
    logic                  rw;
    logic                  first;
    logic                  nak;
    logic [7:0]            ptr;
    logic                  sda_oe;
    logic [7:0]            wr_addr;
    logic [7:0]            wr_data;
    logic                  wr_en;
    logic                  rd_en;
    logic [isr_pkg::TMO_W-1:0] tmo;
  } isr_sl_t;

  localparam isr_sl_t SL_RESET = '{
    scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
    st: isr_pkg::SL_IDLE,
    default: '0
  };

  localparam logic [isr_pkg::TMO_W-1:0] TMO_LIM = TIMEOUT_CYCLES[isr_pkg::TMO_W-1:0];

  isr_sl_t q;
  isr_sl_t d;

  function automatic logic [1:0] strap_bits(input logic [1:0] cls);
    strap_bits = STRAP_MAP[{cls, 1'b0} +: 2];
  endfunction

  function automatic logic addr_match(input logic [6:0] a, input logic [1:0] cls);
    if (FIXED_VARIANT) begin
      addr_match = (a == isr_pkg::FIXED_ADDR_BYTE[7:1]);
    end else begin
      addr_match = (a == {isr_pkg::ADDR_HI, strap_bits(cls)});
    end
  endfunction

  logic       start_c;
  logic       stop_c;
  logic       rise_c;
  logic       fall_c;
  logic [1:0] cls_c;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.wr_en = 1'b0;
    d.rd_en = 1'b0;
    // line synchronisers
    d.scl_s1 = bus.scl;
    d.scl_s2 = q.scl_s1;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    d.pin_s1 = address_select_pin;
    d.pin_s2 = q.pin_s1;
    d.scl_p  = q.scl_s2;
    d.sda_p  = q.sda_s2;

    start_c = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    stop_c  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;
    rise_c  = q.scl_s2 & ~q.scl_p;
    fall_c  = ~q.scl_s2 & q.scl_p;

    // strap detection against bus line levels
    if (q.scl_s2 && !q.sda_s2) begin
      d.p10 = q.pin_s2;
    end
    if (!q.scl_s2 && q.sda_s2) begin
      d.p01      = q.pin_s2;
      d.p01_seen = 1'b1;
    end
    cls_c = {q.p10, q.p01_seen ? q.p01 : q.p10};

    case (q.st)
      isr_pkg::SL_ADDR, isr_pkg::SL_RECV: begin
        if (rise_c) begin
          d.sh   = {q.sh[6:0], q.sda_s2};
          d.bitc = q.bitc + 4'h1;
        end
        if (fall_c && q.bitc == isr_pkg::BYTE_BITS) begin
          d.bitc = '0;
          if (q.st == isr_pkg::SL_ADDR) begin
            if (addr_match(q.sh[7:1], cls_c)) begin
              d.rw     = q.sh[0];
              d.first  = ~q.sh[0];
              d.sda_oe = 1'b1;
              d.st     = isr_pkg::SL_ACK;
            end else begin
              d.st = isr_pkg::SL_IDLE;
            end
          end else begin
            if (q.first) begin
              d.ptr   = q.sh;
              d.first = 1'b0;
            end else begin
              d.wr_en   = 1'b1;
              d.wr_addr = q.ptr;
              d.wr_data = q.sh;
              d.ptr     = ptr_next;
            end
            d.sda_oe = 1'b1;
            d.st     = isr_pkg::SL_ACK;
          end
        end
      end
      isr_pkg::SL_ACK: begin
        if (fall_c) begin
          d.sda_oe = 1'b0;
          d.bitc   = '0;
          if (q.rw) begin
            d.sh     = rd_data;
            d.rd_en  = 1'b1;
            d.ptr    = ptr_next;
            d.sda_oe = ~rd_data[7];
            d.st     = isr_pkg::SL_SEND;
          end else begin
            d.st = isr_pkg::SL_RECV;
          end
        end
      end
      isr_pkg::SL_SEND: begin
        if (rise_c) begin
          d.bitc = q.bitc + 4'h1;
        end
        if (fall_c) begin
          if (q.bitc == isr_pkg::BYTE_BITS) begin
            d.sda_oe = 1'b0;
            d.st     = isr_pkg::SL_MACK;
          end else begin
            d.sh     = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
      end
      isr_pkg::SL_MACK: begin
        if (rise_c) begin
          d.nak = q.sda_s2;
        end
        if (fall_c) begin
          if (q.nak) begin
            d.st = isr_pkg::SL_IDLE;
          end else begin
            d.sh     = rd_data;
            d.rd_en  = 1'b1;
            d.ptr    = ptr_next;
            d.sda_oe = ~rd_data[7];
            d.bitc   = '0;
            d.st     = isr_pkg::SL_SEND;
          end
        end
      end
      isr_pkg::SL_IDLE: begin
        d.sda_oe = 1'b0;
      end
      default: begin
        d.st     = isr_pkg::SL_IDLE;
        d.sda_oe = 1'b0;
      end
    endcase

    // bus timeout watchdog
    if (!timeout_disable && q.st != isr_pkg::SL_IDLE && (!q.scl_s2 || !q.sda_s2)) begin
      d.tmo = q.tmo + 1'b1;
    end else begin
      d.tmo = '0;
    end
    if (q.tmo >= TMO_LIM) begin
      d.st     = isr_pkg::SL_IDLE;
      d.sda_oe = 1'b0;
      d.tmo    = '0;
    end

    if (stop_c) begin
      d.st     = isr_pkg::SL_IDLE;
      d.sda_oe = 1'b0;
      d.first  = 1'b0;
    end
    if (start_c) begin
      d.st     = isr_pkg::SL_ADDR;
      d.bitc   = '0;
      d.sda_oe = 1'b0;
      d.first  = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge link_clk) begin
    if (!rst_n) begin
      q <= SL_RESET;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus.s_sda_o  = 1'b0;
  assign bus.s_sda_oe = q.sda_oe;
  assign ptr          = q.ptr;
  assign wr_addr      = q.wr_addr;
  assign wr_data      = q.wr_data;
  assign wr_en        = q.wr_en;
  assign rd_en        = q.rd_en;

endmodule

// ==== core/isr_master.sv ====
`timescale 1ns/1ns
module isr_master (
  input  wire logic       clk,
  input  wire logic       rst_n,
  isr_bus_if.master       bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_read,
  input  wire logic       cmd_nack,
  input  wire logic [7:0] cmd_wdata,
  output logic            done,
  output logic [7:0]      rdata,
  output logic            ack_rx
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic                   sda_s1;
    logic                   sda_s2;
    isr_pkg::isr_ms_state_t st;
    logic [isr_pkg::QTR_W-1:0] div;
    logic [1:0]             qtr;
    logic [3:0]             bitn;
    logic                   start;
    logic                   stop;
    logic                   rd;
    logic                   nack;
    logic [7:0]             sh;
    logic                   scl_oe;
    logic                   sda_oe;
    logic                   ready;
    logic                   done;
    logic [7:0]             rdata;
    logic                   ack;
  } isr_ms_t;

  localparam isr_ms_t MS_RESET = '{
    sda_s1: 1'b1, sda_s2: 1'b1, st: isr_pkg::MS_IDLE, ready: 1'b1, default: '0
  };
  localparam longint QTR_M1 = isr_pkg::QTR_CYC - 64'd1;
  localparam logic [isr_pkg::QTR_W-1:0] QTR_LAST = QTR_M1[isr_pkg::QTR_W-1:0];

  isr_ms_t q;
  isr_ms_t d;
  logic    tick;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.done   = 1'b0;
    d.sda_s1 = bus.sda;
    d.sda_s2 = q.sda_s1;
    tick     = (q.div == QTR_LAST);
    d.div    = (q.st == isr_pkg::MS_IDLE || tick) ? '0 : q.div + 1'b1;
    if (tick) begin
      d.qtr = q.qtr + 2'h1;
    end
    case (q.st)
      isr_pkg::MS_IDLE: begin
        if (cmd_valid) begin
          d.ready = 1'b0;
          d.start = cmd_start;
          d.stop  = cmd_stop;
          d.rd    = cmd_read;
          d.nack  = cmd_nack;
          d.sh    = cmd_wdata;
          d.qtr   = 2'h0;
          d.bitn  = '0;
          d.st    = cmd_start ? isr_pkg::MS_START : isr_pkg::MS_BIT;
        end
      end
      isr_pkg::MS_START: begin
        if (tick) begin
          case (q.qtr)
            2'h0: begin
              d.scl_oe = 1'b1;
              d.sda_oe = 1'b0;
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.st     = isr_pkg::MS_BIT;
            end
          endcase
        end
      end
      isr_pkg::MS_BIT: begin
        if (tick) begin
          case (q.qtr)
            2'h0: begin
              if (q.bitn == isr_pkg::ACK_BIT) begin
                d.sda_oe = q.rd & ~q.nack;
              end else begin
                d.sda_oe = ~q.rd & ~q.sh[7];
              end
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitn == isr_pkg::ACK_BIT) begin
                d.ack = ~q.sda_s2;
              end else begin
                d.sh = {q.sh[6:0], q.sda_s2};
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.bitn   = q.bitn + 4'h1;
              if (q.bitn == isr_pkg::ACK_BIT) begin
                d.rdata = q.sh;
                d.st    = q.stop ? isr_pkg::MS_STOP : isr_pkg::MS_DONE;
              end
            end
          endcase
        end
      end
      isr_pkg::MS_STOP: begin
        if (tick) begin
          case (q.qtr)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: d.st = isr_pkg::MS_DONE;
          endcase
        end
      end
      isr_pkg::MS_DONE: begin
        d.done  = 1'b1;
        d.ready = 1'b1;
        d.st    = isr_pkg::MS_IDLE;
      end
      default: d.st = isr_pkg::MS_IDLE;
    endcase
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= MS_RESET;
    end else begin
      q <= d;
    end
  end

  assign bus.m_scl_o  = 1'b0;
  assign bus.m_scl_oe = q.scl_oe;
  assign bus.m_sda_o  = 1'b0;
  assign bus.m_sda_oe = q.sda_oe;
  assign cmd_ready    = q.ready;
  assign done         = q.done;
  assign rdata        = q.rdata;
  assign ack_rx       = q.ack;

endmodule

// ==== testbench/isr_checker.sv ====
`timescale 1ns/1ns
module isr_checker #(
  parameter int unsigned TMO = 2000
) (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic m_scl_o,
  input wire logic m_scl_oe,
  input wire logic s_sda_o,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic timeout_disable
);
  // ****************************************
  // helper counters
  // ****************************************
  localparam int HI_MIN = 2 * int'(isr_pkg::QTR_CYC) - 2;
  int unsigned hi_q;
  int unsigned low_q;
  always_ff @(posedge clk) begin
    hi_q <= (!rst_n || !scl) ? 0 : hi_q + 1;
  end
  always_ff @(posedge link_clk) begin
    low_q <= (!rst_n || !s_sda_oe) ? 0 : low_q + 1;
  end
  // ****************************************
  // properties
  // ****************************************
  sequence s_stop;
    scl && $past(scl) && sda && !$past(sda);
  endsequence
  property p_sda_od;
    @(posedge link_clk) disable iff (!rst_n) !s_sda_o;
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("slave drives sda high");
  property p_scl_od;
    @(posedge clk) disable iff (!rst_n) !m_scl_o;
  endproperty
  a_scl_od: assert property (p_scl_od) else $error("master drives scl high");
  property p_stable;
    @(posedge link_clk) disable iff (!rst_n) scl && $past(scl) |-> $stable(s_sda_oe);
  endproperty
  a_stable: assert property (p_stable) else $error("slave sda moved in scl high");
  property p_after_stop;
    @(posedge link_clk) disable iff (!rst_n) s_stop |=> !s_sda_oe [*8];
  endproperty
  a_after_stop: assert property (p_after_stop) else $error("drive after stop");
  property p_sync;
    @(posedge link_clk) disable iff (!rst_n)
      $rose(s_sda_oe) |-> !scl && !$past(scl, 2) && $past(scl, 6);
  endproperty
  a_sync: assert property (p_sync) else $error("sda drive not after synced fall");
  property p_hold;
    @(posedge link_clk) disable iff (!rst_n) $fell(s_sda_oe) |-> !scl;
  endproperty
  a_hold: assert property (p_hold) else $error("ack released in scl high");
  property p_reset;
    @(posedge link_clk) !rst_n |=> !s_sda_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("sda driven in reset");
  property p_tmo;
    @(posedge link_clk) disable iff (!rst_n) !timeout_disable |-> low_q <= TMO + 4;
  endproperty
  a_tmo: assert property (p_tmo) else $error("sda held low past timeout");
  property p_scl_high;
    @(posedge clk) disable iff (!rst_n) $fell(scl) |-> hi_q >= HI_MIN;
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase short");
endmodule

// ==== testbench/test_i2c_slave_register_port.sv ====
`timescale 1ns/1ns
module test_i2c_slave_register_port;
  // ****************************************
  // bench signals
  // ****************************************
  localparam int unsigned TMO = 2000;
  typedef struct packed {
    logic [3:0] f;
    logic [7:0] d;
    logic [1:0] k;
    logic [7:0] e;
  } isr_row_t;
  // flags: start, stop, read, nack; k: 1 ack, 2 data
  localparam isr_row_t ROWS [14] = '{
    '{4'h8, 8'h98, 2'h1, 8'h01}, '{4'h0, 8'h10, 2'h1, 8'h01},
    '{4'h0, 8'hA5, 2'h1, 8'h01}, '{4'h4, 8'h3C, 2'h1, 8'h01},
    '{4'h8, 8'h98, 2'h1, 8'h01}, '{4'h4, 8'h11, 2'h1, 8'h01},
    '{4'h8, 8'h99, 2'h1, 8'h01}, '{4'h2, 8'h00, 2'h2, 8'h3C},
    '{4'h7, 8'h00, 2'h2, 8'hED}, '{4'h8, 8'h98, 2'h1, 8'h01},
    '{4'h0, 8'h10, 2'h1, 8'h01}, '{4'h8, 8'h99, 2'h1, 8'h01},
    '{4'h7, 8'h00, 2'h2, 8'hA5}, '{4'hC, 8'h9C, 2'h1, 8'h00}
  };
  logic       clk;
  logic       link_clk;
  logic       rst_n;
  logic       address_select_pin;
  logic       timeout_disable;
  logic       cmd_valid;
  logic       cmd_start;
  logic       cmd_stop;
  logic       cmd_read;
  logic       cmd_nack;
  logic [7:0] cmd_wdata;
  logic       cmd_ready;
  logic       done;
  logic [7:0] rdata;
  logic       ack_rx;
  logic [7:0] ptr;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic       wr_en;
  logic       rd_en;
  logic [7:0] regs [256];
  int         error_cnt;
  int         n_tests;
  wire [7:0]  ptr_next = ptr + 8'h01;
  wire [7:0]  rd_data = regs[ptr];
  logic [7:0] ptr_f;
  int         rd_cnt = 0;
  wire [7:0]  ptr_f_next = ptr_f + 8'h01;
  wire [7:0]  rd_data_f = regs[ptr_f];
  isr_bus_if bus ();
  // fixed-address slave listens on a mirror of the bus
  isr_bus_if bus_f ();
  assign bus_f.m_scl_o  = 1'b0;
  assign bus_f.m_scl_oe = ~bus.scl;
  assign bus_f.m_sda_o  = 1'b0;
  assign bus_f.m_sda_oe = ~bus.sda;
  isr_master i_isr_master (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
    .cmd_nack(cmd_nack), .cmd_wdata(cmd_wdata), .done(done), .rdata(rdata), .ack_rx(ack_rx));
  isr_slave #(.TIMEOUT_CYCLES(TMO)) i_isr_slave (.link_clk(link_clk), .rst_n(rst_n),
    .bus(bus), .address_select_pin(address_select_pin), .timeout_disable(timeout_disable),
    .ptr(ptr), .ptr_next(ptr_next), .wr_addr(wr_addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_data(rd_data), .rd_en(rd_en));
  isr_checker #(.TMO(TMO)) i_isr_checker (.clk(clk), .link_clk(link_clk), .rst_n(rst_n),
    .m_scl_o(bus.m_scl_o), .m_scl_oe(bus.m_scl_oe), .s_sda_o(bus.s_sda_o),
    .s_sda_oe(bus.s_sda_oe), .scl(bus.scl), .sda(bus.sda), .timeout_disable(timeout_disable));
  isr_slave #(.FIXED_VARIANT(1'b1), .TIMEOUT_CYCLES(TMO)) i_isr_slave_fixed (
    .link_clk(link_clk), .rst_n(rst_n), .bus(bus_f), .address_select_pin(address_select_pin),
    .timeout_disable(timeout_disable), .ptr(ptr_f), .ptr_next(ptr_f_next), .wr_addr(),
    .wr_data(), .wr_en(), .rd_data(rd_data_f), .rd_en());
  always #5 clk = ~clk;
  always begin
    #7 link_clk = ~link_clk;
    #8 link_clk = ~link_clk;
  end
  // register map beside the slave
  always @(posedge link_clk) begin
    if (wr_en === 1'b1) regs[wr_addr] <= wr_data;
    if (rd_en === 1'b1) rd_cnt <= rd_cnt + 1;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(input logic [3:0] f, input logic [7:0] d);
    int n;
    n = 0;
    {cmd_start, cmd_stop, cmd_read, cmd_nack} = f;
    cmd_wdata = d;
    cmd_valid = 1'b1;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, done}, 8'h01);
    chk({7'h00, cmd_ready}, 8'h01);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    #1000000;
    error_cnt++;
    stop_test();
  end
  initial begin
    clk = 1'b0;
    link_clk = 1'b0;
    rst_n = 1'b0;
    address_select_pin = 1'b0;
    timeout_disable = 1'b0;
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = 5'h00;
    cmd_wdata = 8'h00;
    error_cnt = 0;
    n_tests = 0;
    for (int i = 0; i < 256; i++) regs[i] = ~8'(i);
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (200) @(posedge clk);
    #1;
    foreach (ROWS[i]) begin
      op(ROWS[i].f, ROWS[i].d);
      if (ROWS[i].k[0]) chk({7'h00, ack_rx}, ROWS[i].e);
      if (ROWS[i].k[1]) chk(rdata, ROWS[i].e);
    end
    chk(ptr, 8'h11);
    chk(ptr_f, 8'h11);
    chk(8'(rd_cnt), 8'h03);
    address_select_pin = 1'b1;
    op(4'h8, 8'h9A);
    chk({7'h00, ack_rx}, 8'h01);
    op(4'h4, 8'h66);
    chk(ptr, 8'h66);
    chk(ptr_f, 8'h11);
    op(4'h8, 8'h98);
    chk({7'h00, ack_rx}, 8'h00);
    op(4'h4, 8'h55);
    chk(ptr, 8'h66);
    chk(ptr_f, 8'h55);
    address_select_pin = 1'b0;
    for (int t = 0; t < 2; t++) begin
      timeout_disable = (t == 0);
      op(4'h8, 8'h98);
      repeat (4000) @(posedge clk);
      #1;
      op(4'h4, 8'h20 + 8'(t));
      chk({7'h00, ack_rx}, (t == 0) ? 8'h01 : 8'h00);
      chk(ptr, 8'h20);
    end
    op(4'h8, 8'h98);
    op(4'h4, 8'h90);
    op(4'h8, 8'h99);
    chk({7'h00, ack_rx}, 8'h01);
    repeat (4000) @(posedge clk);
    #1;
    chk({7'h00, bus.sda}, 8'h01);
    op(4'h8, 8'h98);
    op(4'h0, 8'h40);
    rst_n = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk(ptr, 8'h00);
    chk({7'h00, bus.sda}, 8'h01);
    rst_n = 1'b1;
    repeat (200) @(posedge clk);
    #1;
    op(4'hC, 8'h98);
    chk({7'h00, ack_rx}, 8'h01);
    stop_test();
  end
endmodule
